// *** hdl/ssr_pkg.sv ***
/*
  package for the soft-start ramp profile controller: register map,
  field positions, reset values, modes and timing constants.
  assumes a single 100 MHz clock and an AHB-Lite register bus.
*/
package ssr_pkg;

  // register byte offsets
  localparam logic [7:0] SSR_CTRL_OFS = 8'h00;
  localparam logic [7:0] SSR_MODE_OFS = 8'h04;
  localparam logic [7:0] SSR_PROF1_OFS = 8'h08;
  localparam logic [7:0] SSR_PROF2_OFS = 8'h0C;
  localparam logic [7:0] SSR_KICK1_OFS = 8'h10;
  localparam logic [7:0] SSR_KICK2_OFS = 8'h14;
  localparam logic [7:0] SSR_VOLT_OFS = 8'h18;
  localparam logic [7:0] SSR_DECEL_OFS = 8'h1C;
  localparam logic [7:0] SSR_GAIN_OFS = 8'h20;
  localparam logic [7:0] SSR_STAT_OFS = 8'h24;
  localparam logic [7:0] SSR_OUT_OFS = 8'h28;

  // ctrl register bit positions
  localparam int SSR_CTRL_RUN_BIT = 0;
  localparam int SSR_CTRL_SELEN_BIT = 1;

  // control tick: one setpoint update per millisecond
  localparam int SSR_TICK_NS = 1000000;
  localparam int SSR_CLK_NS = 10;
  localparam int SSR_TICK_CYC = SSR_TICK_NS / SSR_CLK_NS;

  // full scale of levels (100 percent)
  localparam logic [15:0] SSR_FULL = 16'hFFFF;

  // reset values
  localparam logic [31:0] SSR_PROF_RST = 32'h0064_4000;
  localparam logic [31:0] SSR_KICK_RST = 32'h0000_0000;
  localparam logic [31:0] SSR_VOLT_RST = 32'h0064_4000;
  localparam logic [31:0] SSR_DECEL_RST = 32'h0064_2000;
  localparam logic [31:0] SSR_GAIN_RST = 32'h0010_0010;

  // start modes
  typedef enum logic [1:0] {
    SSR_MODE_CUR = 2'h0,
    SSR_MODE_VOLT = 2'h1,
    SSR_MODE_TACH = 2'h2,
    SSR_MODE_TRQ = 2'h3
  } ssr_start_t;

  // run states
  typedef enum logic [4:0] {
    SSR_ST_IDLE = 5'b00001,
    SSR_ST_KICK = 5'b00010,
    SSR_ST_RAMP = 5'b00100,
    SSR_ST_RUN = 5'b01000,
    SSR_ST_DECEL = 5'b10000
  } ssr_state_t;

  // one ramp profile: initial, max, ramp time in ticks
  typedef struct packed {
    logic [15:0] ramp_ticks;
    logic [7:0] max_lvl;
    logic [7:0] init_lvl;
  } ssr_prof_t;

  // one kick profile
  typedef struct packed {
    logic [15:0] kick_ticks;
    logic [7:0] rsvd;
    logic [7:0] kick_lvl;
  } ssr_kick_t;

  // feedback from power stage
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] speed;
    logic [15:0] torque;
  } ssr_fb_t;

endpackage : ssr_pkg

// *** hdl/ssr_ramp_ctrl.sv ***
/*
  soft-start ramp profile controller: kick, current / voltage / tach
  ramps, dual ramp profile selection in current and tach modes, dual kick selection in all modes, and voltage or torque decel.
  assumes feedback words from the power stage synchronous to ref_clk,
  ramp-select and stop/up-to-speed inputs from pins, AHB-Lite master.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module ssr_ramp_ctrl
  import ssr_pkg::*;
#(
  parameter int TICK_CYC = SSR_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ramp_sel_pin,
  input wire logic stop_pin,
  input wire logic uts_timer_pin,
  input wire ssr_fb_t fb,
  output logic [15:0] volt_cmd,
  output logic [15:0] cur_cmd,
  output logic up_to_speed
);

  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 16777215) begin
      $error("TICK_CYC out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers and state
  logic [31:0] ctrl_q, mode_q, volt_q, decel_q, gain_q;
  ssr_prof_t prof_q [2];
  ssr_kick_t kick_q [2];
  ssr_state_t state_q;
  logic [15:0] elapsed_q, kick_cnt_q;
  logic [23:0] tick_cnt_q;
  logic tick;
  logic [2:0] sel_sync_q, stop_sync_q, uts_sync_q;
  logic sel_q;
  logic [15:0] dec_start_q;
  logic [31:0] integ_q;
  logic [15:0] cur_err_prev_q;
  logic [31:0] cur_integ_q;
  logic [31:0] addr_q;
  logic wr_q, act_q;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_sync_q <= 3'h0;
      stop_sync_q <= 3'h0;
      uts_sync_q <= 3'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[1:0], ramp_sel_pin};
      stop_sync_q <= {stop_sync_q[1:0], stop_pin};
      uts_sync_q <= {uts_sync_q[1:0], uts_timer_pin};
    end
  end

  // control tick divider
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 24'h000000;
    end else if (tick) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end
  assign tick = (tick_cnt_q == 24'(TICK_CYC - 1));

  //////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      act_q <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q <= hwrite;
      act_q <= hsel && htrans[1];
    end
  end

  // writable register bank
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 32'h0000_0000;
      mode_q <= 32'h0000_0000;
      prof_q[0] <= SSR_PROF_RST;
      prof_q[1] <= SSR_PROF_RST;
      kick_q[0] <= SSR_KICK_RST;
      kick_q[1] <= SSR_KICK_RST;
      volt_q <= SSR_VOLT_RST;
      decel_q <= SSR_DECEL_RST;
      gain_q <= SSR_GAIN_RST;
    end else if (act_q && wr_q) begin
      if (addr_q[7:0] == SSR_CTRL_OFS) begin
        ctrl_q <= hwdata;
      end else if (addr_q[7:0] == SSR_MODE_OFS) begin
        mode_q <= hwdata;
      end else if (addr_q[7:0] == SSR_PROF1_OFS) begin
        prof_q[0] <= hwdata;
      end else if (addr_q[7:0] == SSR_PROF2_OFS) begin
        prof_q[1] <= hwdata;
      end else if (addr_q[7:0] == SSR_KICK1_OFS) begin
        kick_q[0] <= hwdata;
      end else if (addr_q[7:0] == SSR_KICK2_OFS) begin
        kick_q[1] <= hwdata;
      end else if (addr_q[7:0] == SSR_VOLT_OFS) begin
        volt_q <= hwdata;
      end else if (addr_q[7:0] == SSR_DECEL_OFS) begin
        decel_q <= hwdata;
      end else if (addr_q[7:0] == SSR_GAIN_OFS) begin
        gain_q <= hwdata;
      end
    end
  end

  // read mux, unmapped reads zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == SSR_CTRL_OFS) begin
        hrdata <= ctrl_q;
      end else if (haddr[7:0] == SSR_MODE_OFS) begin
        hrdata <= mode_q;
      end else if (haddr[7:0] == SSR_PROF1_OFS) begin
        hrdata <= prof_q[0];
      end else if (haddr[7:0] == SSR_PROF2_OFS) begin
        hrdata <= prof_q[1];
      end else if (haddr[7:0] == SSR_KICK1_OFS) begin
        hrdata <= kick_q[0];
      end else if (haddr[7:0] == SSR_KICK2_OFS) begin
        hrdata <= kick_q[1];
      end else if (haddr[7:0] == SSR_VOLT_OFS) begin
        hrdata <= volt_q;
      end else if (haddr[7:0] == SSR_DECEL_OFS) begin
        hrdata <= decel_q;
      end else if (haddr[7:0] == SSR_GAIN_OFS) begin
        hrdata <= gain_q;
      end else if (haddr[7:0] == SSR_STAT_OFS) begin
        hrdata <= {11'h000, sel_q, up_to_speed, 3'h0, state_q, elapsed_q[10:0]};
      end else if (haddr[7:0] == SSR_OUT_OFS) begin
        hrdata <= {cur_cmd, volt_cmd};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // always ready, always OKAY
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // profile selection
  ssr_start_t mode;
  ssr_prof_t prof;
  ssr_kick_t kick;
  logic run_cmd, cur_mode;
  assign mode = ssr_start_t'(mode_q[1:0]);
  assign run_cmd = ctrl_q[SSR_CTRL_RUN_BIT];
  // tach ramp shares the current settings
  assign cur_mode = (mode == SSR_MODE_CUR) || (mode == SSR_MODE_TACH);
  assign prof = (cur_mode && sel_q) ? prof_q[1] : prof_q[0];
  assign kick = sel_q ? kick_q[1] : kick_q[0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= 1'b0;
    end else if (!up_to_speed) begin
      sel_q <= ctrl_q[SSR_CTRL_SELEN_BIT] & sel_sync_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // linear interpolation helper
  function automatic logic [15:0] lerp(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic [15:0] t,
                                       input logic [15:0] n);
    logic [32:0] span;
    logic [32:0] step;
    span = (b >= a) ? {17'h0, b - a} : {17'h0, a - b};
    step = (n == 16'h0000) ? span : (span * {17'h0, t}) / {17'h0, n};
    if (b >= a) begin
      lerp = a + step[15:0];
    end else begin
      lerp = a - step[15:0];
    end
  endfunction

  logic [15:0] init16, max16, ramp_sp, dec_sp, dec_end, volt_sp;
  assign init16 = {prof.init_lvl, 8'h00};
  assign max16 = {prof.max_lvl, 8'h00};
  assign dec_end = {decel_q[7:0], 8'h00};
  assign ramp_sp = lerp(init16, max16,
    (elapsed_q > prof.ramp_ticks) ? prof.ramp_ticks : elapsed_q,
    prof.ramp_ticks);
  assign volt_sp = lerp({volt_q[7:0], 8'h00}, SSR_FULL,
    (elapsed_q > volt_q[31:16]) ? volt_q[31:16] : elapsed_q, volt_q[31:16]);
  // from stop voltage (voltage mode) or stop torque over decel time
  assign dec_sp = lerp(dec_start_q, dec_end,
    (elapsed_q > decel_q[31:16]) ? decel_q[31:16] : elapsed_q,
    decel_q[31:16]);

  //////////////////////////////////////////////////////////////////////
  // run state machine
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SSR_ST_IDLE;
      elapsed_q <= 16'h0000;
      kick_cnt_q <= 16'h0000;
      up_to_speed <= 1'b0;
      dec_start_q <= 16'h0000;
    end else begin
      case (state_q)
        SSR_ST_IDLE: begin
          up_to_speed <= 1'b0;
          elapsed_q <= 16'h0000;
          kick_cnt_q <= 16'h0000;
          if (run_cmd && !stop_sync_q[1]) begin
            state_q <= SSR_ST_KICK;
          end
        end
        SSR_ST_KICK: begin
          if (kick_cnt_q >= kick.kick_ticks) begin
            state_q <= SSR_ST_RAMP;
          end else if (tick) begin
            kick_cnt_q <= kick_cnt_q + 16'h0001;
          end
        end
        SSR_ST_RAMP: begin
          if (stop_sync_q[1] || !run_cmd) begin
            dec_start_q <= (mode == SSR_MODE_VOLT) ? volt_cmd : fb.torque;
            elapsed_q <= 16'h0000;
            state_q <= SSR_ST_DECEL;
          end else if (uts_sync_q[1]) begin
            up_to_speed <= 1'b1;
            state_q <= SSR_ST_RUN;
          end else if (tick && elapsed_q != 16'hFFFF) begin
            elapsed_q <= elapsed_q + 16'h0001;
          end
        end
        SSR_ST_RUN: begin
          if (stop_sync_q[1] || !run_cmd) begin
            // leaving run drops the up-to-speed status
            up_to_speed <= 1'b0;
            dec_start_q <= (mode == SSR_MODE_VOLT) ? SSR_FULL : fb.torque;
            elapsed_q <= 16'h0000;
            state_q <= SSR_ST_DECEL;
          end
        end
        SSR_ST_DECEL: begin
          if (elapsed_q >= decel_q[31:16]) begin
            state_q <= SSR_ST_IDLE;
          end else if (tick) begin
            elapsed_q <= elapsed_q + 16'h0001;
          end
        end
        default: begin
          state_q <= SSR_ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // tach speed loop: PI speed, demand clamped to max current
  logic [15:0] spd_ref, spd_err, cur_dem;
  logic [31:0] pi_out;
  assign spd_ref = lerp(16'h0000, SSR_FULL,
    (elapsed_q > prof.ramp_ticks) ? prof.ramp_ticks : elapsed_q,
    prof.ramp_ticks);
  assign spd_err = (spd_ref > fb.speed) ? spd_ref - fb.speed : 16'h0000;
  assign pi_out = integ_q + {16'h0000, spd_err} * {24'h000000, gain_q[7:0]};
  assign cur_dem = (pi_out[31:8] > {8'h00, max16}) ? max16 :
                   ((pi_out[31:8] < {8'h00, init16}) ? init16 : pi_out[23:8]);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      integ_q <= 32'h0000_0000;
    end else if (state_q != SSR_ST_RAMP || mode != SSR_MODE_TACH) begin
      integ_q <= 32'h0000_0000;
    end else if (tick && cur_dem != max16) begin
      integ_q <= integ_q + {16'h0000, spd_err};
    end
  end

  // inner PID current loop on volt output
  logic [15:0] cur_err;
  logic [31:0] pid_out;
  assign cur_err = (cur_cmd > fb.current) ? cur_cmd - fb.current : 16'h0000;
  assign pid_out = cur_integ_q
    + {16'h0000, cur_err} * {24'h000000, gain_q[23:16]}
    + {16'h0000, (cur_err > cur_err_prev_q) ? cur_err - cur_err_prev_q
                                            : 16'h0000};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_integ_q <= 32'h0000_0000;
      cur_err_prev_q <= 16'h0000;
    end else if (state_q == SSR_ST_IDLE) begin
      cur_integ_q <= 32'h0000_0000;
      cur_err_prev_q <= 16'h0000;
    end else if (tick) begin
      cur_integ_q <= cur_integ_q + {16'h0000, cur_err};
      cur_err_prev_q <= cur_err;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output commands
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      volt_cmd <= 16'h0000;
      cur_cmd <= 16'h0000;
    end else begin
      case (state_q)
        SSR_ST_KICK: begin
          cur_cmd <= {kick.kick_lvl, 8'h00};
          volt_cmd <= SSR_FULL;
        end
        SSR_ST_RAMP: begin
          if (!stop_sync_q[1] && run_cmd && uts_sync_q[1]) begin
            volt_cmd <= SSR_FULL;
            cur_cmd <= SSR_FULL;
          end else if (mode == SSR_MODE_VOLT) begin
            volt_cmd <= volt_sp;
            cur_cmd <= SSR_FULL;
          end else if (mode == SSR_MODE_TACH) begin
            cur_cmd <= cur_dem;
            volt_cmd <= (pid_out[31:8] > 32'h0000_FFFF) ? SSR_FULL
                                                        : pid_out[23:8];
          end else begin
            cur_cmd <= ramp_sp;
            volt_cmd <= SSR_FULL;
          end
        end
        SSR_ST_RUN: begin
          volt_cmd <= SSR_FULL;
          cur_cmd <= SSR_FULL;
        end
        SSR_ST_DECEL: begin
          if (mode == SSR_MODE_VOLT) begin
            volt_cmd <= dec_sp;
          end else begin
            cur_cmd <= dec_sp;
          end
        end
        default: begin
          volt_cmd <= 16'h0000;
          cur_cmd <= 16'h0000;
        end
      endcase
    end
  end

endmodule // ssr_ramp_ctrl

// *** bench/ssr_ramp_ctrl_properties.sv ***
/*
  checker for the ramp controller: bus answers, run and stop relations.
  assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
module ssr_ramp_ctrl_chk
  import ssr_pkg::*;
#(
  parameter int TICK_CYC = SSR_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ramp_sel_pin,
  input wire logic stop_pin,
  input wire logic uts_timer_pin,
  input wire ssr_fb_t fb,
  input wire logic [15:0] volt_cmd,
  input wire logic [15:0] cur_cmd,
  input wire logic up_to_speed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic rd_take;
  // read address phase taken
  assign rd_take = hsel && htrans[1] && hready && !hwrite;

  sequence read_taken;
    rd_take;
  endsequence
  sequence unmapped_read;
    read_taken ##0 (haddr[31:8] == 24'h0 && haddr[7:0] > SSR_OUT_OFS);
  endsequence

  ////////////////////////////////////////////////////////////////////
  hready_one_a: assert property (hreadyout) // CONTRACT
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) // CONTRACT
    else $error("hresp not okay");
  unmapped_zero_a: assert property (unmapped_read |=> hrdata == 32'h0) // CONTRACT
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata)) // CONTRACT
    else $error("hrdata moved without read");
  full_volt_a: assert property (up_to_speed |-> volt_cmd == SSR_FULL)
    else $error("not full voltage at speed");
  uts_cause_a: assert property ($rose(up_to_speed) |-> $past(uts_timer_pin, 2))
    else $error("up to speed without timer");
  stop_decel_a: assert property ($rose(stop_pin) && up_to_speed |-> ##[1:8] !up_to_speed)
    else $error("stop did not leave run");
  stop_hold_a: assert property (stop_pin [*8] |-> !up_to_speed)
    else $error("at speed while stopping");
endmodule // ssr_ramp_ctrl_chk

bind ssr_ramp_ctrl ssr_ramp_ctrl_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ramp_sel_pin(ramp_sel_pin), .stop_pin(stop_pin),
  .uts_timer_pin(uts_timer_pin), .fb(fb), .volt_cmd(volt_cmd),
  .cur_cmd(cur_cmd), .up_to_speed(up_to_speed)
);

// *** bench/ssr_motor_model.sv ***
/*
  behavioural power stage: feedback follows the commands after a lag.
  assumes commands come from the controller on ref_clk.
*/
`timescale 1ns/1ps
module ssr_motor_model
  import ssr_pkg::*;
#(
  parameter int LAG = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] volt_cmd,
  input wire logic [15:0] cur_cmd,
  output ssr_fb_t fb
);
  logic [7:0] lag_q;

  // feedback refresh once every LAG cycles, slow stage when large
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lag_q <= 8'h00;
      fb <= '0;
    end else if (lag_q >= 8'(LAG - 1)) begin
      lag_q <= 8'h00;
      fb.current <= cur_cmd;
      fb.torque <= cur_cmd;
      fb.speed <= volt_cmd;
    end else begin
      lag_q <= lag_q + 8'h01;
    end
  end
endmodule // ssr_motor_model

// *** bench/tb_top.sv ***
/*
  testbench for the ramp controller: register access, ramps, profile
  select and both decel kinds. assumes a short control tick.
*/
`timescale 1ns/1ps
module tb_top import ssr_pkg::*; ();
  localparam int TK = 8;
  logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, up_to_speed;
  logic ramp_sel_pin, stop_pin, uts_timer_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] volt_cmd, cur_cmd, v1, v2, v0;
  ssr_fb_t fb;
  int errors, tests_run;

  ssr_ramp_ctrl #(.TICK_CYC(TK)) u_ssr_ramp_ctrl (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ramp_sel_pin(ramp_sel_pin), .stop_pin(stop_pin),
    .uts_timer_pin(uts_timer_pin), .fb(fb), .volt_cmd(volt_cmd),
    .cur_cmd(cur_cmd), .up_to_speed(up_to_speed));
  ssr_motor_model #(.LAG(3)) u_ssr_motor_model (.ref_clk(ref_clk),
    .nrst(nrst), .volt_cmd(volt_cmd), .cur_cmd(cur_cmd), .fb(fb));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2;
    hwrite <= wr; hsize <= 3'h2;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rd = hrdata;
    if (n >= 99) errors++;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    @(negedge ref_clk);
    check(32'({hreadyout, up_to_speed}), 32'h2); // RESET
    check({volt_cmd, cur_cmd}, 32'h0); // RESET
    @(posedge ref_clk) nrst <= 1'b1;
    rdchk(SSR_CTRL_OFS, 32'h0); // RESET
    rdchk(SSR_PROF1_OFS, SSR_PROF_RST);
    rdchk(SSR_PROF2_OFS, SSR_PROF_RST);
    rdchk(SSR_KICK1_OFS, SSR_KICK_RST);
    rdchk(SSR_KICK2_OFS, SSR_KICK_RST);
    rdchk(SSR_VOLT_OFS, SSR_VOLT_RST);
    rdchk(SSR_DECEL_OFS, SSR_DECEL_RST);
    rdchk(SSR_GAIN_OFS, SSR_GAIN_RST);
    $display("test_reset done");
  endtask

  task automatic test_regs();
    bus(1'b1, SSR_PROF1_OFS, 32'h0028_8010);
    bus(1'b1, SSR_PROF2_OFS, 32'h0028_F010);
    bus(1'b1, SSR_KICK1_OFS, 32'h0002_0030);
    bus(1'b1, SSR_KICK2_OFS, 32'h0003_0050);
    bus(1'b1, 8'h40, 32'hA5A5_5A5A);
    rdchk(SSR_PROF1_OFS, 32'h0028_8010);
    rdchk(SSR_PROF2_OFS, 32'h0028_F010);
    rdchk(SSR_KICK1_OFS, 32'h0002_0030);
    rdchk(SSR_KICK2_OFS, 32'h0003_0050);
    rdchk(8'h40, 32'h0); // CONTRACT
    $display("test_regs done");
  endtask

  task automatic test_volt();
    bus(1'b1, SSR_MODE_OFS, 32'h1);
    bus(1'b1, SSR_VOLT_OFS, 32'h0064_0040);
    bus(1'b1, SSR_DECEL_OFS, 32'h0008_1000);
    bus(1'b1, SSR_CTRL_OFS, 32'h1);
    ticks(8);
    v1 = volt_cmd;
    ticks(4);
    v2 = volt_cmd;
    check(32'(v2 > v1), 32'h1);
    check(32'(v2 != SSR_FULL), 32'h1);
    check(32'(up_to_speed), 32'h0);
    @(posedge ref_clk) uts_timer_pin <= 1'b1;
    ticks(1);
    check(32'(volt_cmd), 32'(SSR_FULL));
    check(32'(up_to_speed), 32'h1);
    @(posedge ref_clk) stop_pin <= 1'b1;
    ticks(3);
    v1 = volt_cmd;
    check(32'(v1 < SSR_FULL), 32'h1);
    check(32'(up_to_speed), 32'h0);
    bus(1'b1, SSR_CTRL_OFS, 32'h0);
    ticks(10);
    @(posedge ref_clk) stop_pin <= 1'b0;
    uts_timer_pin <= 1'b0;
    $display("test_volt done");
  endtask

  task automatic test_sel();
    bus(1'b1, SSR_MODE_OFS, 32'h0);
    bus(1'b1, SSR_CTRL_OFS, 32'h3);
    ticks(20);
    v1 = cur_cmd;
    bus(1'b0, SSR_STAT_OFS, 32'h0);
    check(32'(rd[20]), 32'h0);
    @(posedge ref_clk) ramp_sel_pin <= 1'b1;
    ticks(2);
    v2 = cur_cmd;
    check(32'(v2 > v1), 32'h1);
    bus(1'b0, SSR_STAT_OFS, 32'h0);
    check(32'(rd[20]), 32'h1);
    @(posedge ref_clk) uts_timer_pin <= 1'b1;
    ticks(1);
    @(posedge ref_clk) ramp_sel_pin <= 1'b0;
    ticks(1);
    bus(1'b0, SSR_STAT_OFS, 32'h0);
    check(32'(rd[20]), 32'h1);
    bus(1'b1, SSR_CTRL_OFS, 32'h0);
    ticks(10);
    @(posedge ref_clk) uts_timer_pin <= 1'b0;
    ramp_sel_pin <= 1'b1;
    bus(1'b1, SSR_CTRL_OFS, 32'h1);
    ticks(3);
    bus(1'b0, SSR_STAT_OFS, 32'h0);
    check(32'(rd[20]), 32'h0);
    bus(1'b1, SSR_CTRL_OFS, 32'h0);
    ticks(10);
    bus(1'b1, SSR_MODE_OFS, 32'h2);
    bus(1'b1, SSR_CTRL_OFS, 32'h3);
    ticks(3);
    bus(1'b0, SSR_STAT_OFS, 32'h0);
    check(32'(rd[20]), 32'h1);
    bus(1'b1, SSR_CTRL_OFS, 32'h0);
    ticks(10);
    @(posedge ref_clk) ramp_sel_pin <= 1'b0;
    $display("test_sel done");
  endtask

  task automatic test_trq();
    bus(1'b1, SSR_MODE_OFS, 32'h3);
    bus(1'b1, SSR_DECEL_OFS, 32'h000C_2000);
    bus(1'b1, SSR_CTRL_OFS, 32'h1);
    ticks(12);
    @(posedge ref_clk) uts_timer_pin <= 1'b1;
    ticks(2);
    v0 = cur_cmd;
    @(posedge ref_clk) stop_pin <= 1'b1;
    ticks(3);
    v1 = cur_cmd;
    ticks(4);
    v2 = cur_cmd;
    check(32'(v1 <= v0), 32'h1);
    check(32'(v2 < v1), 32'h1);
    check(32'(up_to_speed), 32'h0);
    bus(1'b1, SSR_CTRL_OFS, 32'h0);
    ticks(8);
    @(posedge ref_clk) stop_pin <= 1'b0;
    uts_timer_pin <= 1'b0;
    $display("test_trq done");
  endtask

  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    ramp_sel_pin = 1'b0; stop_pin = 1'b0; uts_timer_pin = 1'b0;
    errors = 0; tests_run = 0;
    repeat (4) @(posedge ref_clk);
    test_reset();
    test_regs();
    test_volt();
    test_sel();
    test_trq();
    print_verdict();
  end

  // watchdog against a hung wait
  initial begin
    #300000;
    errors++;
    print_verdict();
  end
endmodule // tb_top
